// >>> hdl/udc_defines.vh
// Command codes, field positions and reset values for the command block
`ifndef UDC_DEFINES_VH
`define UDC_DEFINES_VH
`define UDC_CMD_CFG_WR      8'h20
`define UDC_CMD_CFG_RD      8'h30
`define UDC_CMD_STAT_RD     8'h50
`define UDC_CMD_ERR_RD      8'ha0
`define UDC_CMD_UNLOCK      8'hb0
`define UDC_CMD_SCR_WR      8'hb2
`define UDC_CMD_SCR_RD      8'hb3
`define UDC_CMD_FRM_RD      8'hb4
`define UDC_CMD_ID_RD       8'hb5
`define UDC_CMD_ADR_WR      8'hb6
`define UDC_CMD_ADR_RD      8'hb7
`define UDC_CMD_IRQ_RD      8'hc0
`define UDC_CMD_CHK_RD      8'hd0
`define UDC_CMD_SETUP_ACK   8'hf4
`define UDC_CFG_FIFO_EN     7
`define UDC_CFG_DIR         6
`define UDC_CFG_DBL         5
`define UDC_CFG_ISO         4
`define UDC_ADR_DEV_EN      7
`define UDC_CFG_RESET       8'h00
`define UDC_ADR_RESET       8'h00
`define UDC_BUS_RST_ADDR    7'h00
`define UDC_UNLOCK_CODE     16'haa37
`define UDC_LAST_EP         4'hf
`endif

// >>> hdl/udc_word_count.v
// Byte-to-word count for the parallel data bus
`timescale 1ns/100ps
module udc_word_count
#(
	parameter NB = 11
)
(
	bytes_n,
	bus16,
	words_n
);
	input  wire [NB-1:0] bytes_n;
	input  wire          bus16;
	output wire [NB-1:0] words_n;
	wire [NB:0] sum;
	assign sum = {1'b0, bytes_n} + {{NB{1'b0}}, 1'b1};
	// Odd count rounds up; the last upper byte is then padding
	assign words_n = bus16 ? sum[NB:1] : bytes_n;
endmodule

// >>> hdl/udc_cmd_core.v
// Command decoder, endpoint configuration and device address logic
// What this block does
// - Code f4 acknowledges setup on both control directions, no data.
// - Codes a0 to af read one endpoint error code word.
// - Code b0 plus one word unlocks writes to all writable registers.
// - On a 16-bit bus N bytes take (N+1)/2 words.
// - Status check reads a copy and changes no status or interrupt bit.
// - 8-bit register on a 16-bit bus: upper byte invalid.
// - Config written 20 to 2f, read 30 to 3f, one word each.
// - USB bus reset disables every endpoint.
// - FIFO allocation starts after endpoint 15 config in full sequence.
// - Allocation-affecting change invalidates all endpoint FIFO contents.
// - Bit 7 fifo_enable: FIFO enabled and allocated when set.
// - Bit 6 endpoint_direction: 0 OUT/DMA read, 1 IN/DMA write.
// - Bit 5 double_buffer, bit 4 isochronous_select.
// - Bits 3 to 0 fifo_size_code; all config bits reset to zero.
// - Address register written b6, read b7, one word each.
// - Bit 7 device_enable, bits 6 to 0 address; both reset zero.
// - Bus reset uses address 00 and enables, register value kept.
// - New address applies only when host acks the empty IN packet.
`timescale 1ns/100ps
`include "udc_defines.vh"
module udc_cmd_core
#(
	parameter NB = 11
)
(
	input  wire          clk,
	input  wire          reset,
	input  wire          bus16,
	input  wire          cmd_wr,
	input  wire [7:0]    cmd_code,
	input  wire          data_wr,
	input  wire [15:0]   data_in,
	input  wire          data_rd,
	output reg  [15:0]   data_out,
	output wire          setup_ack,
	input  wire          usb_bus_reset,
	input  wire          in_ack_ep0,
	input  wire [127:0]  ep_error_codes,
	input  wire [127:0]  ep_status,
	input  wire [7:0]    frame_low,
	input  wire [2:0]    frame_high,
	input  wire [15:0]   part_identity_reg,
	input  wire [31:0]   irq_source_reg,
	input  wire [NB-1:0] xfer_bytes,
	output wire [NB-1:0] xfer_words,
	output wire [127:0]  endpoint_config,
	output reg           fifo_alloc_start,
	output reg           fifo_invalidate,
	output reg  [6:0]    active_address,
	output reg           active_enable,
	output wire [7:0]    device_address_reg
);
	// ****************************************
	// Command state
	// ****************************************
	localparam ST_IDLE = 3'b001;
	localparam ST_WR   = 3'b010;
	localparam ST_RD   = 3'b100;
	reg [2:0]   state_q;
	reg [7:0]   cmd_q;
	reg         word_q;
	reg         unlocked_q;
	reg [7:0]   cfg_q [0:15];
	reg [15:0]  seq_q;
	reg [7:0]   adr_q;
	reg         adr_pend_q;
	reg [15:0]  scratch_q;
	wire [3:0]  idx;
	wire        cfg_wr_go;
	wire        allocation_change;
	integer     i;
	integer     j;
	wire [7:0]  sel_code;
	wire [3:0]  sel_idx;
	wire        take_cmd;
	wire        take_rd;
	wire        irq_second;
	wire        hit_cfg_rd;
	wire        hit_stat_rd;
	wire        hit_chk_rd;
	wire        hit_err_rd;
	wire        hit_scr_rd;
	wire        hit_frm_rd;
	wire        hit_id_rd;
	wire        hit_adr_rd;
	wire        hit_irq_rd;
	reg  [15:0] rd_word_d;
	reg  [7:0]  rd_byte_d;
	reg         rd_byte_sel;
	assign idx = cmd_q[3:0];
	assign setup_ack = cmd_wr && (cmd_code == `UDC_CMD_SETUP_ACK);
	assign device_address_reg = adr_q;
	assign cfg_wr_go = (state_q == ST_WR) && data_wr && unlocked_q &&
		(cmd_q[7:4] == 4'h2);
	// Size or enable change moves FIFO boundaries
	assign allocation_change = cfg_wr_go &&
		((cfg_q[idx][`UDC_CFG_FIFO_EN] != data_in[`UDC_CFG_FIFO_EN]) ||
		(cfg_q[idx][3:0] != data_in[3:0]));
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1)
		begin : g_cfg
			// Fields: enable, direction, double, iso, size
			assign endpoint_config[8*g+7:8*g] = cfg_q[g];
		end
	endgenerate
	udc_word_count #(.NB(NB)) u_wc
	(
		.bytes_n (xfer_bytes),
		.bus16   (bus16),
		.words_n (xfer_words)
	);
	// ****************************************
	// Read decode
	// ****************************************
	// Code taken this edge wins, else the one in force
	assign sel_code = cmd_wr ? cmd_code : cmd_q;
	assign sel_idx = sel_code[3:0];
	assign take_cmd = cmd_wr;
	assign take_rd = (state_q == ST_RD) && data_rd;
	assign irq_second = take_rd && !word_q && (cmd_q == `UDC_CMD_IRQ_RD);
	assign hit_cfg_rd = (sel_code[7:4] == 4'h3);
	assign hit_stat_rd = (sel_code[7:4] == 4'h5);
	assign hit_chk_rd = (sel_code[7:4] == 4'hd);
	assign hit_err_rd = (sel_code[7:4] == 4'ha);
	assign hit_scr_rd = (sel_code == `UDC_CMD_SCR_RD);
	assign hit_frm_rd = (sel_code == `UDC_CMD_FRM_RD);
	assign hit_id_rd = (sel_code == `UDC_CMD_ID_RD);
	assign hit_adr_rd = (sel_code == `UDC_CMD_ADR_RD);
	assign hit_irq_rd = (sel_code == `UDC_CMD_IRQ_RD);
	always @*
	begin
		rd_byte_sel = 1'b1;
		rd_byte_d = 8'h00;
		rd_word_d = 16'h0000;
		// Byte-wide registers
		if (hit_cfg_rd)
			rd_byte_d = cfg_q[sel_idx];
		else if (hit_stat_rd || hit_chk_rd)
			rd_byte_d = ep_status[8*sel_idx+:8];
		else if (hit_err_rd)
			rd_byte_d = ep_error_codes[8*sel_idx+:8];
		else if (hit_adr_rd)
			rd_byte_d = adr_q;
		else
			rd_byte_sel = 1'b0;
		// Word-wide registers
		if (hit_scr_rd)
			rd_word_d = scratch_q;
		else if (hit_frm_rd)
			rd_word_d = {5'h00, frame_high, frame_low};
		else if (hit_id_rd)
			rd_word_d = part_identity_reg;
		else if (hit_irq_rd)
			rd_word_d = irq_source_reg[15:0];
		else
			rd_word_d = 16'h0000;
	end
	// ****************************************
	// Endpoint configuration store
	// ****************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			for (j = 0; j < 16; j = j + 1)
				cfg_q[j] <= `UDC_CFG_RESET;
		end
		else
		begin
			if (cfg_wr_go)
				cfg_q[idx] <= data_in[7:0];
			// Bus reset wins over the enable bit of a write in the same cycle
			if (usb_bus_reset)
			begin
				for (j = 0; j < 16; j = j + 1)
					cfg_q[j][`UDC_CFG_FIFO_EN] <= 1'b0;
			end
		end
	end
	// ****************************************
	// Allocation sequence and invalidate
	// ****************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			seq_q <= 16'h0000;
			fifo_alloc_start <= 1'b0;
			fifo_invalidate <= 1'b0;
		end
		else
		begin
			fifo_alloc_start <= 1'b0;
			// Firmware must drain FIFOs first; data is lost here
			fifo_invalidate <= allocation_change;
			if (cfg_wr_go)
			begin
				// Any skip restarts the walk from ep0 OUT
				if (idx == 4'h0)
					seq_q <= 16'h0001;
				else if (seq_q[idx-4'h1])
					seq_q <= seq_q | (16'h0001 << idx);
				else
					seq_q <= 16'h0000;
				if (idx == `UDC_LAST_EP && seq_q[14])
					fifo_alloc_start <= 1'b1;
			end
		end
	end
	// ****************************************
	// Decode and register writes
	// ****************************************
	always @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= ST_IDLE;
			cmd_q <= 8'h00;
			word_q <= 1'b0;
			unlocked_q <= 1'b1;
			adr_q <= `UDC_ADR_RESET;
			adr_pend_q <= 1'b0;
			scratch_q <= 16'h0000;
			active_address <= 7'h00;
			active_enable <= 1'b0;
		end
		else
		begin
			if (cmd_wr)
			begin
				cmd_q <= cmd_code;
				word_q <= 1'b0;
				case (cmd_code[7:4])
				4'h2: state_q <= ST_WR;
				4'h3, 4'h5, 4'ha, 4'hd: state_q <= ST_RD;
				4'hb: state_q <= cmd_code[0] ? ST_RD : ST_WR;
				4'hc: state_q <= ST_RD;
				default: state_q <= ST_IDLE;
				endcase
			end
			else if (state_q == ST_WR && data_wr)
			begin
				state_q <= ST_IDLE;
				if (cmd_q == `UDC_CMD_UNLOCK)
					unlocked_q <= (data_in == `UDC_UNLOCK_CODE);
				else if (unlocked_q)
				begin
					if (cmd_q == `UDC_CMD_SCR_WR)
						scratch_q <= data_in;
					if (cmd_q == `UDC_CMD_ADR_WR)
					begin
						adr_q <= data_in[7:0];
						adr_pend_q <= 1'b1;
					end
				end
			end
			else if (state_q == ST_RD && data_rd)
			begin
				// Interrupt read spans two words
				if (cmd_q == `UDC_CMD_IRQ_RD && !word_q)
					word_q <= 1'b1;
				else
					state_q <= ST_IDLE;
			end
			if (usb_bus_reset)
			begin
				active_address <= `UDC_BUS_RST_ADDR;
				active_enable <= 1'b1;
				adr_pend_q <= 1'b0;
			end
			else if (adr_pend_q && in_ack_ep0)
			begin
				adr_pend_q <= 1'b0;
				active_address <= adr_q[6:0];
				active_enable <= adr_q[`UDC_ADR_DEV_EN];
			end
		end
	end
	// ****************************************
	// Read data
	// ****************************************
	always @(posedge clk)
	begin
		if (reset)
			data_out <= 16'h0000;
		else if (take_cmd)
		begin
			// Copy only: nothing here clears status
			if (rd_byte_sel)
				data_out <= {8'h00, rd_byte_d};
			else
				data_out <= rd_word_d;
		end
		else if (irq_second)
			data_out <= irq_source_reg[31:16];
	end
endmodule

// >>> dv/udc_cmd_checker.sv
// Port assertions for the command block
`timescale 1ns/100ps
module udc_cmd_checker
#(
	parameter NB = 11
)
(
	input wire          clk,
	input wire          reset,
	input wire          bus16,
	input wire          cmd_wr,
	input wire [7:0]    cmd_code,
	input wire          data_wr,
	input wire [15:0]   data_out,
	input wire          setup_ack,
	input wire          usb_bus_reset,
	input wire          in_ack_ep0,
	input wire [NB-1:0] xfer_bytes,
	input wire [NB-1:0] xfer_words,
	input wire [127:0]  endpoint_config,
	input wire          fifo_alloc_start,
	input wire [6:0]    active_address,
	input wire          active_enable,
	input wire [7:0]    device_address_reg
);
	// ****************
	// Rules at the ports
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire [127:0] fen  = endpoint_config & {16{8'h80}};
	wire [NB:0]  half = ({1'b0, xfer_bytes} + 1'b1) >> 1;
	property p_ack; setup_ack == (cmd_wr && cmd_code == 8'hf4); endproperty
	a_ack: assert property (p_ack) else $error("bad ack");
	property p_ben; usb_bus_reset |=> fen == 0; endproperty
	a_ben: assert property (p_ben) else $error("ep still on");
	property p_badr; usb_bus_reset |=> active_enable && !active_address;
	endproperty
	a_badr: assert property (p_badr) else $error("bus adr");
	property p_breg; usb_bus_reset && !data_wr |=> $stable(device_address_reg);
	endproperty
	a_breg: assert property (p_breg) else $error("adr reg moved");
	property p_words; xfer_words == (bus16 ? half[NB-1:0] : xfer_bytes);
	endproperty
	a_words: assert property (p_words) else $error("word count");
	// Bus reset may also move it, so that edge is excluded
	property p_adr; $changed(active_address) && !$past(usb_bus_reset)
		|-> $past(in_ack_ep0); endproperty
	a_adr: assert property (p_adr) else $error("early adr");
	property p_alloc; fifo_alloc_start |-> $past(data_wr && cmd_code == 8'h2f);
	endproperty
	a_alloc: assert property (p_alloc) else $error("stray alloc");
	property p_rd8; $past(cmd_wr && cmd_code == 8'hb7) |-> !data_out[15:8];
	endproperty
	a_rd8: assert property (p_rd8) else $error("upper byte");
endmodule
bind udc_cmd_core udc_cmd_checker #(.NB(NB)) i_chk (.*);

// >>> dv/udc_cpu_model.sv
// Processor model issuing commands and words
`timescale 1ns/100ps
module udc_cpu_model
(
	input  wire        clk,
	output reg         cmd_wr,
	output reg  [7:0]  cmd_code,
	output reg         data_wr,
	output reg  [15:0] data_in,
	output reg         data_rd
);
	initial {cmd_wr, cmd_code, data_wr, data_in, data_rd} = 0;
	// Only legal codes are ever passed in
	task cmd(input [7:0] c);
		@(negedge clk) {cmd_wr, cmd_code} = {1'b1, c};
		@(negedge clk) cmd_wr = 0;
	endtask
	// Released bus shows inverted junk, not the old word
	task wr(input [15:0] d);
		@(negedge clk) {data_wr, data_in} = {1'b1, d};
		@(negedge clk) {data_wr, data_in} = {1'b0, ~d};
	endtask
	task rd;
		@(negedge clk) data_rd = 1;
		@(negedge clk) data_rd = 0;
	endtask
endmodule

// >>> dv/udc_cmd_core_bench.sv
// Self-checking bench for the command block
`timescale 1ns/100ps
module udc_cmd_core_bench;
	reg          clk, reset, bus16, usb_bus_reset, in_ack_ep0;
	reg  [127:0] ep_error_codes, ep_status;
	reg  [7:0]   frame_low;
	reg  [2:0]   frame_high;
	reg  [15:0]  part_identity_reg;
	reg  [31:0]  irq_source_reg;
	reg  [10:0]  xfer_bytes;
	wire [10:0]  xfer_words;
	wire [15:0]  data_in, data_out;
	wire [7:0]   cmd_code, device_address_reg;
	wire [127:0] endpoint_config;
	wire [6:0]   active_address;
	wire         cmd_wr, data_wr, data_rd, setup_ack, active_enable;
	wire         fifo_alloc_start, fifo_invalidate;
	integer      mismatches, n_compared, n_alloc, n_ack, n_inv, i;
	reg  [47:0]  rows [0:2];
	udc_cpu_model i_cpu (.*);
	udc_cmd_core #(.NB(11)) i_dut (.*);
	initial
	begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (!reset && fifo_alloc_start) n_alloc <= n_alloc + 1;
		if (!reset && setup_ack) n_ack <= n_ack + 1;
		if (!reset && fifo_invalidate) n_inv <= n_inv + 1;
	end
	task chk(input [127:0] seen, exp, input string what);
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("[ERR] %0s exp %h seen %h", what, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches = mismatches + 1;
		tally_and_finish;
	end
	// ****************
	// Main sequence
	// ****************
	initial
	begin
		rows[0] = {8'h21, 16'hff5a, 8'h31, 16'h005a};
		rows[1] = {8'h2f, 16'h00df, 8'h3f, 16'h00df};
		rows[2] = {8'hb6, 16'h7785, 8'hb7, 16'h0085};
		{mismatches, n_compared, n_alloc, n_ack, n_inv} = 0;
		{reset, bus16, usb_bus_reset, in_ack_ep0, xfer_bytes} = 15'h4000;
		{frame_low, frame_high, part_identity_reg, irq_source_reg} = 0;
		for (i = 0; i < 16; i = i + 1)
			ep_error_codes[i*8+:8] = 8'h30 + i;
		ep_status = ~ep_error_codes;
		repeat (8) @(negedge clk);
		reset = 0;
		chk(endpoint_config, 0, "cfg rst");
		chk(device_address_reg, 0, "adr rst");
		for (i = 0; i < 3; i = i + 1)
		begin
			i_cpu.cmd(rows[i][47:40]);
			i_cpu.wr(rows[i][39:24]);
			i_cpu.cmd(rows[i][23:16]);
			chk(data_out, rows[i][15:0], "row");
			i_cpu.rd;
		end
		// All 16 endpoints go in order from ep0 OUT, each enabled with size code equal to its index
		for (i = 0; i < 16; i = i + 1)
		begin
			i_cpu.cmd(8'h20 + i);
			i_cpu.wr(16'h0080 | i);
		end
		@(negedge clk);
		chk(n_alloc, 1, "alloc");
		chk(n_inv, 17, "inval");
		chk(endpoint_config[127:120], 8'h8f, "ep15");
		@(negedge clk) usb_bus_reset = 1;
		@(negedge clk) usb_bus_reset = 0;
		chk(endpoint_config & {16{8'h80}}, 0, "ep en");
		chk({active_enable, active_address}, 8'h80, "bus adr");
		chk(device_address_reg, 8'h85, "adr reg");
		i_cpu.cmd(8'hb6);
		i_cpu.wr(16'h0093);
		chk(active_address, 0, "early adr");
		@(negedge clk) in_ack_ep0 = 1;
		@(negedge clk) in_ack_ep0 = 0;
		chk({active_enable, active_address}, 8'h93, "new adr");
		for (i = 0; i < 2; i = i + 1)
		begin
			i_cpu.cmd(8'hb0);
			i_cpu.wr(i ? 16'haa37 : 16'h0001);
			i_cpu.cmd(8'hb6);
			i_cpu.wr(16'h0044);
			chk(device_address_reg, i ? 8'h44 : 8'h93, "lock");
		end
		for (i = 0; i < 16; i = i + 1)
		begin
			i_cpu.cmd(8'ha0 + i);
			chk(data_out, ep_error_codes[i*8+:8], "err");
			i_cpu.rd;
			i_cpu.cmd(8'hd0 + i);
			chk(data_out, ep_status[i*8+:8], "copy");
			i_cpu.rd;
		end
		i_cpu.cmd(8'hf4);
		chk(n_ack, 1, "ack");
		{frame_low, frame_high} = {8'h5c, 3'h5};
		{part_identity_reg, irq_source_reg} = {16'h1c3a, 32'h1234_8765};
		i_cpu.cmd(8'hb2);
		i_cpu.wr(16'hbeef);
		i_cpu.cmd(8'hb3);
		chk(data_out, 16'hbeef, "scratch");
		i_cpu.rd;
		i_cpu.cmd(8'hb4);
		chk(data_out, 16'h055c, "frame");
		i_cpu.rd;
		i_cpu.cmd(8'hb5);
		chk(data_out, 16'h1c3a, "id");
		i_cpu.rd;
		i_cpu.cmd(8'hc0);
		chk(data_out, 16'h8765, "irq lo");
		i_cpu.rd;
		chk(data_out, 16'h1234, "irq hi");
		i_cpu.rd;
		{bus16, xfer_bytes} = {1'b1, 11'd1023};
		#1 chk(xfer_words, 512, "odd");
		bus16 = 0;
		#1 chk(xfer_words, 1023, "bytes");
		tally_and_finish;
	end
endmodule
